// *** src/tsec_top.sv ***
// Two stage event controller: peripheral routing stage and core event stage
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "tsec_params.svh"

module tsec_top #(
    parameter int N_SRC = 56,
    parameter int N_GP = 9
) (
    input wire logic clk,
    input wire logic srst,
    input wire tsec_pkg::tsec_addr_t reg_addr,
    input wire tsec_pkg::tsec_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic supervisor_mode,
    output tsec_pkg::tsec_word_t reg_rdata,
    input wire logic [N_SRC-1:0] periph_irq,
    input wire logic global_irq_on_instr,
    input wire logic global_irq_off_instr,
    input wire logic core_idle,
    input wire logic event_accept,
    input wire logic event_return,
    output logic service_req,
    output tsec_pkg::tsec_route_t service_id,
    output tsec_pkg::tsec_event_vec_t active_event_nest,
    output logic wake_request
);
    import tsec_pkg::*;

    // ======================================================================
    // Elaboration checks
    generate
        if (N_SRC <= 32 || N_SRC > 64 || N_SRC > `TSEC_ASSIGN_REGS * `TSEC_FIELDS_PER_REG) begin : g_bad_src
            $error("tsec_top: N_SRC must lie in 33..56");
        end
        if (N_GP != 9) begin : g_bad_gp
            $error("tsec_top: N_GP must be 9");
        end
    endgenerate

    localparam logic [31:0] ASSIGN_RST [`TSEC_ASSIGN_REGS] = '{
        `TSEC_ASSIGN0_RST, `TSEC_ASSIGN1_RST, `TSEC_ASSIGN2_RST, `TSEC_ASSIGN3_RST,
        `TSEC_ASSIGN4_RST, `TSEC_ASSIGN5_RST, `TSEC_ASSIGN6_RST
    };

    // ======================================================================
    // Register bus decode
    logic wr_ok;
    logic rd_ok;
    assign wr_ok = reg_wr && supervisor_mode;
    assign rd_ok = reg_rd && supervisor_mode;

    // ======================================================================
    // Peripheral input synchronisers
    logic [N_SRC-1:0] sync1;
    logic [N_SRC-1:0] sync2;
    logic [N_SRC-1:0] sync3;
    logic [N_SRC-1:0] src_level;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= periph_irq;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A source level changes only once two stages agree
    always_ff @(posedge clk) begin
        if (srst) begin
            src_level <= '0;
        end else begin
            for (int s = 0; s < N_SRC; s++) begin
                if (sync2[s] == sync3[s]) begin
                    src_level[s] <= sync2[s];
                end
            end
        end
    end

    // ======================================================================
    // Peripheral enable and wake enable words
    logic [63:0] periph_irq_enable;
    logic [63:0] periph_wake_enable;

    always_ff @(posedge clk) begin
        if (srst) begin
            periph_irq_enable <= {`TSEC_PEN_RST, `TSEC_PEN_RST};
        end else if (wr_ok && reg_addr == `TSEC_OFF_PEN_LO) begin
            periph_irq_enable[31:0] <= reg_wdata;
        end else if (wr_ok && reg_addr == `TSEC_OFF_PEN_HI) begin
            periph_irq_enable[63:32] <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            periph_wake_enable <= {`TSEC_WAKE_RST, `TSEC_WAKE_RST};
        end else if (wr_ok && reg_addr == `TSEC_OFF_WAKE_LO) begin
            periph_wake_enable[31:0] <= reg_wdata;
        end else if (wr_ok && reg_addr == `TSEC_OFF_WAKE_HI) begin
            periph_wake_enable[63:32] <= reg_wdata;
        end
    end

    // ======================================================================
    // Route assignment words
    logic [31:0] periph_route_assign [`TSEC_ASSIGN_REGS];

    always_ff @(posedge clk) begin
        if (srst) begin
            for (int r = 0; r < `TSEC_ASSIGN_REGS; r++) begin
                periph_route_assign[r] <= ASSIGN_RST[r];
            end
        end else if (wr_ok) begin
            for (int r = 0; r < `TSEC_ASSIGN_REGS; r++) begin
                if (reg_addr == `TSEC_OFF_ASSIGN0 + 8'(r * 4)) begin
                    periph_route_assign[r] <= reg_wdata;
                end
            end
        end
    end

    // ======================================================================
    // Routing: combine enabled sources onto general core inputs
    logic [N_GP-1:0] gp_line;

    always_comb begin
        tsec_route_t field;
        field = '0;
        gp_line = '0;
        for (int s = 0; s < N_SRC; s++) begin
            field = periph_route_assign[s / 8][(s % 8) * 4 +: 4];
            for (int g = 0; g < N_GP; g++) begin
                // Values above 8 select no input
                if (field == 4'(g) && src_level[s] && periph_irq_enable[s]) begin
                    gp_line[g] = 1'b1;
                end
            end
        end
    end

    // ======================================================================
    // Rising edge detection on the general core inputs
    logic [N_GP-1:0] gp_q;
    logic [N_GP-1:0] gp_qq;
    logic [N_GP-1:0] gp_rise;

    always_ff @(posedge clk) begin
        if (srst) begin
            gp_q <= '0;
            gp_qq <= '0;
        end else begin
            gp_q <= gp_line;
            gp_qq <= gp_q;
        end
    end

    assign gp_rise = gp_q & ~gp_qq;

    // ======================================================================
    // Global enable driven by the on and off instructions
    logic global_en;

    always_ff @(posedge clk) begin
        if (srst) begin
            global_en <= 1'b0;
        end else if (global_irq_off_instr) begin
            global_en <= 1'b0;
        end else if (global_irq_on_instr) begin
            global_en <= 1'b1;
        end
    end

    // ======================================================================
    // Core enable register
    tsec_event_vec_t core_event_enable;

    always_ff @(posedge clk) begin
        if (srst) begin
            core_event_enable <= `TSEC_CORE_EN_RST;
        end else if (wr_ok && reg_addr == `TSEC_OFF_CORE_EN) begin
            core_event_enable <= reg_wdata[15:0];
        end
    end

    // ======================================================================
    // Latch and nest registers
    tsec_event_vec_t latched_event_flags;
    tsec_event_vec_t next_latched;
    tsec_event_vec_t next_nest;
    tsec_event_vec_t accept_mask;
    tsec_event_vec_t return_mask;
    logic latch_wr;

    assign latch_wr = wr_ok && reg_addr == `TSEC_OFF_LATCH;

    // Accept only lands on a bit still latched while service_req is high
    always_comb begin
        accept_mask = '0;
        if (event_accept && latched_event_flags[service_id] && service_req) begin
            accept_mask[service_id] = 1'b1;
        end
    end

    // Return retires the highest priority active general event
    always_comb begin
        return_mask = '0;
        if (event_return) begin
            for (int k = 15; k >= 7; k--) begin
                if (active_event_nest[k]) begin
                    return_mask = '0;
                    return_mask[k] = 1'b1;
                end
            end
        end
    end

    always_comb begin
        next_latched = latched_event_flags;
        for (int g = 0; g < N_GP; g++) begin
            if (latch_wr && !core_event_enable[g + 7]) begin
                next_latched[g + 7] = reg_wdata[g + 7];
            end
            if (accept_mask[g + 7]) begin
                next_latched[g + 7] = 1'b0;
            end
            // A new edge wins over the clear on acceptance
            if (gp_rise[g]) begin
                next_latched[g + 7] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            latched_event_flags <= '0;
        end else begin
            latched_event_flags <= next_latched;
        end
    end

    assign next_nest = (active_event_nest & ~return_mask) | accept_mask;

    always_ff @(posedge clk) begin
        if (srst) begin
            active_event_nest <= '0;
        end else begin
            active_event_nest <= next_nest;
        end
    end

    // ======================================================================
    // Priority selection with nesting
    logic cand_any;
    tsec_route_t cand_id;

    always_comb begin
        logic blocked;
        blocked = 1'b0;
        cand_any = 1'b0;
        cand_id = '0;
        for (int k = 7; k <= 15; k++) begin
            // Only events above every active one may nest
            if (active_event_nest[k]) begin
                blocked = 1'b1;
            end
            if (!blocked && !cand_any && global_en && latched_event_flags[k]
                    && core_event_enable[k]) begin
                cand_any = 1'b1;
                cand_id = 4'(k);
            end
        end
    end

    // Registered request keeps edge-to-nest at three cycles or more
    always_ff @(posedge clk) begin
        if (srst) begin
            service_req <= 1'b0;
            service_id <= '0;
        end else if (event_accept) begin
            service_req <= 1'b0;
            service_id <= cand_id;
        end else begin
            service_req <= cand_any;
            service_id <= cand_id;
        end
    end

    // ======================================================================
    // Wake request
    logic wake_cause;
    assign wake_cause = |(src_level & periph_wake_enable[N_SRC-1:0]);

    always_ff @(posedge clk) begin
        if (srst) begin
            wake_request <= 1'b0;
        end else if (|active_event_nest[15:7] || !core_idle) begin
            wake_request <= 1'b0;
        end else if (wake_cause) begin
            wake_request <= 1'b1;
        end
    end

    // ======================================================================
    // Read data, one cycle after the strobe
    tsec_word_t rd_mux;
    logic [63:0] src_word;
    assign src_word = 64'(src_level);

    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            `TSEC_OFF_LATCH: rd_mux = {16'h0000, latched_event_flags};
            `TSEC_OFF_CORE_EN: rd_mux = {16'h0000, core_event_enable};
            `TSEC_OFF_NEST: rd_mux = {16'h0000, active_event_nest};
            `TSEC_OFF_GLOBAL: rd_mux = {31'h00000000, global_en};
            `TSEC_OFF_PEN_LO: rd_mux = periph_irq_enable[31:0];
            `TSEC_OFF_PEN_HI: rd_mux = periph_irq_enable[63:32];
            `TSEC_OFF_SRC_LO: rd_mux = src_word[31:0];
            `TSEC_OFF_SRC_HI: rd_mux = src_word[63:32];
            `TSEC_OFF_WAKE_LO: rd_mux = periph_wake_enable[31:0];
            `TSEC_OFF_WAKE_HI: rd_mux = periph_wake_enable[63:32];
            default: begin
                for (int r = 0; r < `TSEC_ASSIGN_REGS; r++) begin
                    if (reg_addr == `TSEC_OFF_ASSIGN0 + 8'(r * 4)) begin
                        rd_mux = periph_route_assign[r];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (rd_ok) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule

// *** src/tsec_params.svh ***
// Offsets, field positions, reset values and timing counts of the event controller
`ifndef TSEC_PARAMS_SVH
`define TSEC_PARAMS_SVH

// ==========================================================================
// Register byte addresses
`define TSEC_OFF_LATCH        8'h00
`define TSEC_OFF_CORE_EN      8'h04
`define TSEC_OFF_NEST         8'h08
`define TSEC_OFF_GLOBAL       8'h0c
`define TSEC_OFF_PEN_LO       8'h10
`define TSEC_OFF_PEN_HI       8'h14
`define TSEC_OFF_SRC_LO       8'h18
`define TSEC_OFF_SRC_HI       8'h1c
`define TSEC_OFF_WAKE_LO      8'h20
`define TSEC_OFF_WAKE_HI      8'h24
`define TSEC_OFF_ASSIGN0      8'h28
`define TSEC_ASSIGN_REGS      7

// ==========================================================================
// Field layout
`define TSEC_GP_BASE          4'h7
`define TSEC_FIELD_W          4
`define TSEC_FIELDS_PER_REG   8
`define TSEC_GLOBAL_EN_BIT    0

// ==========================================================================
// Reset values of the route assignment words, one nibble per source, and of the enable words
`define TSEC_ASSIGN0_RST      32'h00000000
`define TSEC_ASSIGN1_RST      32'h11000000
`define TSEC_ASSIGN2_RST      32'h33332222
`define TSEC_ASSIGN3_RST      32'h44444433
`define TSEC_ASSIGN4_RST      32'h55555555
`define TSEC_ASSIGN5_RST      32'h06666655
`define TSEC_ASSIGN6_RST      32'h33333000
`define TSEC_CORE_EN_RST      16'h0000
`define TSEC_PEN_RST          32'h00000000
`define TSEC_WAKE_RST         32'h00000000

// ==========================================================================
// Timing counts in core clock cycles
`define TSEC_EDGE_DET_CYCLES  2
`define TSEC_MIN_LATENCY      3

`endif

// *** src/tsec_pkg.sv ***
// Types shared by the two stage event controller
package tsec_pkg;
    typedef logic [3:0] tsec_route_t;
    typedef logic [15:0] tsec_event_vec_t;
    typedef logic [7:0] tsec_addr_t;
    typedef logic [31:0] tsec_word_t;
endpackage

// *** bench/tsec_top_chk.sv ***
// Port checker for the two stage event controller
`timescale 1ns/1ps
module tsec_top_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic reg_rd,
    input wire logic supervisor_mode,
    input wire tsec_pkg::tsec_word_t reg_rdata,
    input wire logic core_idle,
    input wire logic event_accept,
    input wire logic event_return,
    input wire logic service_req,
    input wire tsec_pkg::tsec_route_t service_id,
    input wire tsec_pkg::tsec_event_vec_t active_event_nest,
    input wire logic wake_request
);
    import tsec_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ==========================================================
    // Assertions
    rdata_idle_a: assert property (!$past(reg_rd && supervisor_mode) |-> reg_rdata == 0)
        else $error("read data outside its slot");
    nest_low_a: assert property (active_event_nest[6:0] == 7'h00)
        else $error("nest bits below seven set");
    id_range_a: assert property (service_req |-> service_id >= 4'h7)
        else $error("service index below seven");
    prio_order_a: assert property (service_req |->
        (active_event_nest & ((16'h0002 << service_id) - 16'h0001)) == 16'h0000)
        else $error("service offered at or below an active level");
    accept_nest_a: assert property (service_req && event_accept && !event_return
        |=> active_event_nest[$past(service_id)])
        else $error("accepted event not in nest");
    accept_drop_a: assert property (service_req && event_accept |=> !service_req)
        else $error("request held after accept");
    nest_hold_a: assert property (!event_accept && !event_return |=> $stable(active_event_nest))
        else $error("nest changed without cause");
    wake_idle_a: assert property (wake_request |-> $past(core_idle))
        else $error("wake request while core busy");
    cover property (service_req && event_accept);
    cover property (wake_request);
    cover property (event_return);
endmodule

bind tsec_top tsec_top_chk tsec_top_chk_inst (.clk(clk), .srst(srst), .reg_rd(reg_rd),
    .supervisor_mode(supervisor_mode), .reg_rdata(reg_rdata), .core_idle(core_idle),
    .event_accept(event_accept), .event_return(event_return), .service_req(service_req),
    .service_id(service_id), .active_event_nest(active_event_nest),
    .wake_request(wake_request));

// *** bench/tsec_core_model.sv ***
// Pipeline model that takes offered events and later retires them
`timescale 1ns/1ps
module tsec_core_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic service_req,
    input wire tsec_pkg::tsec_event_vec_t active_event_nest,
    input wire logic [3:0] accept_delay,
    input wire logic hold,
    output logic event_accept,
    output logic event_return
);
    import tsec_pkg::*;
    logic [3:0] wait_cnt;
    logic [3:0] ret_cnt;
    always_ff @(posedge clk) begin
        if (srst || !service_req || event_accept) begin
            wait_cnt <= 4'h0;
            event_accept <= 1'b0;
        end else if (wait_cnt >= accept_delay) begin
            event_accept <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // Never retire while an offer is open, so accept and return do not collide
    always_ff @(posedge clk) begin
        if (srst || hold || service_req || active_event_nest == 0 || event_return) begin
            ret_cnt <= 4'h0;
            event_return <= 1'b0;
        end else if (ret_cnt == 4'h5) begin
            event_return <= 1'b1;
        end else begin
            ret_cnt <= ret_cnt + 4'h1;
        end
    end
endmodule

// *** bench/two_stage_event_controller_test.sv ***
// Self-checking bench for the two stage event controller
`timescale 1ns/1ps
`include "tsec_params.svh"
module two_stage_event_controller_test;
    import tsec_pkg::*;
    logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sup = 1'b1;
    logic g_on = 1'b0, g_off = 1'b0, core_idle = 1'b0, hold = 1'b0;
    tsec_addr_t reg_addr = 8'h00;
    tsec_word_t reg_wdata = 32'h0;
    tsec_word_t reg_rdata;
    logic [55:0] periph_irq = 56'h0;
    logic [3:0] acc_dly = 4'h0;
    logic event_accept, event_return, service_req, wake_request;
    tsec_route_t service_id;
    tsec_event_vec_t active_event_nest;
    logic nest_any, nest_none;
    int num_errors = 0;
    int checks_done = 0;
    assign nest_any = (active_event_nest !== 16'h0);
    assign nest_none = (active_event_nest === 16'h0);
    initial forever #20 clk = ~clk;
    tsec_top tsec_top_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .supervisor_mode(sup), .reg_rdata(reg_rdata),
        .periph_irq(periph_irq), .global_irq_on_instr(g_on), .global_irq_off_instr(g_off),
        .core_idle(core_idle), .event_accept(event_accept), .event_return(event_return),
        .service_req(service_req), .service_id(service_id),
        .active_event_nest(active_event_nest), .wake_request(wake_request));
    tsec_core_model tsec_core_model_inst (.clk(clk), .srst(srst), .service_req(service_req),
        .active_event_nest(active_event_nest), .accept_delay(acc_dly), .hold(hold),
        .event_accept(event_accept), .event_return(event_return));
    // ==========================================================
    // Helpers
    function automatic tsec_route_t dflt(input int s);
        if (s <= 13 || (s >= 47 && s <= 50)) return 4'h0;
        if (s <= 15) return 4'h1;
        if (s <= 19) return 4'h2;
        if (s <= 25 || s >= 51) return 4'h3;
        if (s <= 31) return 4'h4;
        return (s <= 41) ? 4'h5 : 4'h6;
    endfunction
    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input tsec_word_t exp, input tsec_word_t got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_for(ref logic s, output int n);
        n = 0;
        while (s !== 1'b1) begin
            @(posedge clk);
            #1;
            n++;
            if (n > 60) begin
                num_errors++;
                $display("MISMATCH wait expected 1 seen %b", s);
                conclude();
            end
        end
    endtask
    task automatic wr(input tsec_addr_t a, input tsec_word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input tsec_addr_t a, input tsec_word_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), exp, reg_rdata);
    endtask
    task automatic src(input int s, input logic v);
        @(posedge clk);
        periph_irq[s] <= v;
    endtask
    task automatic quiet(input int c);
        repeat (c) begin
            @(posedge clk);
            #1;
            check("idle request", 32'h0, 32'(service_req));
        end
    endtask
    task automatic serve(input int s, input tsec_route_t id);
        int n;
        src(s, 1'b1);
        wait_for(service_req, n);
        check("latency", 32'h1, 32'(n >= 3 && n <= 8));
        check("service id", 32'(id), 32'(service_id));
        rd(s < 32 ? 8'h18 : 8'h1c, 32'h1 << (s % 32));
        wait_for(nest_any, n);
        check("nest", 32'h1 << id, 32'(active_event_nest));
        rd(`TSEC_OFF_NEST, 32'h1 << id);
        src(s, 1'b0);
        wait_for(nest_none, n);
    endtask
    // ==========================================================
    // Scenarios
    task automatic s_reset();
        tsec_word_t e;
        for (int w = 0; w < `TSEC_ASSIGN_REGS; w++) begin
            for (int k = 0; k < 8; k++) e[k*4 +: 4] = dflt(w * 8 + k);
            rd(`TSEC_OFF_ASSIGN0 + 8'(w * 4), e);
        end
        rd(8'h80, 32'h0);
        sup <= 1'b0;
        wr(`TSEC_OFF_PEN_LO, 32'hffffffff);
        rd(`TSEC_OFF_CORE_EN, 32'h0);
        sup <= 1'b1;
        rd(`TSEC_OFF_PEN_LO, 32'h0);
    endtask
    task automatic s_route();
        int t[9] = '{0, 14, 16, 20, 26, 32, 42, 50, 55};
        @(posedge clk);
        g_on <= 1'b1;
        @(posedge clk);
        g_on <= 1'b0;
        wr(`TSEC_OFF_CORE_EN, 32'hff80);
        wr(`TSEC_OFF_PEN_LO, 32'hffffffff);
        wr(`TSEC_OFF_PEN_HI, 32'h00ffffff);
        for (int k = 0; k < 9; k++) begin
            acc_dly <= 4'(k % 2 * 3);
            serve(t[k], 4'h7 + dflt(t[k]));
        end
    endtask
    task automatic s_masks();
        wr(`TSEC_OFF_CORE_EN, 32'hff00);
        src(1, 1'b1);
        quiet(12);
        rd(`TSEC_OFF_LATCH, 32'h0080);
        wr(`TSEC_OFF_LATCH, 32'h0180);
        rd(`TSEC_OFF_LATCH, 32'h0080);
        wr(`TSEC_OFF_LATCH, 32'h0);
        wr(`TSEC_OFF_CORE_EN, 32'hff80);
        quiet(6);
        src(1, 1'b0);
        wr(`TSEC_OFF_PEN_LO, 32'hfffffffe);
        src(0, 1'b1);
        quiet(10);
        rd(`TSEC_OFF_SRC_LO, 32'h1);
        src(0, 1'b0);
        quiet(4);
        rd(`TSEC_OFF_SRC_LO, 32'h0);
        wr(`TSEC_OFF_PEN_LO, 32'hffffffff);
        wr(`TSEC_OFF_ASSIGN0 + 8'h04, 32'h18000000);
        serve(14, 4'hf);
        wr(`TSEC_OFF_ASSIGN0 + 8'h04, 32'h11000000);
    endtask
    task automatic s_global();
        int n;
        @(posedge clk);
        g_off <= 1'b1;
        @(posedge clk);
        g_off <= 1'b0;
        src(21, 1'b1);
        quiet(12);
        rd(`TSEC_OFF_LATCH, 32'h0400);
        @(posedge clk);
        g_on <= 1'b1;
        @(posedge clk);
        g_on <= 1'b0;
        wait_for(service_req, n);
        check("service id", 32'ha, 32'(service_id));
        rd(`TSEC_OFF_GLOBAL, 32'h1);
        src(21, 1'b0);
        wait_for(nest_none, n);
    endtask
    task automatic s_queue();
        int n;
        hold <= 1'b1;
        @(posedge clk);
        periph_irq[2:1] <= 2'b11;
        wait_for(service_req, n);
        check("service id", 32'h7, 32'(service_id));
        wait_for(nest_any, n);
        rd(`TSEC_OFF_LATCH, 32'h0);
        src(1, 1'b0);
        src(2, 1'b0);
        quiet(4);
        src(3, 1'b1);
        quiet(8);
        rd(`TSEC_OFF_LATCH, 32'h0080);
        hold <= 1'b0;
        wait_for(service_req, n);
        src(3, 1'b0);
        quiet(3);
        wait_for(nest_none, n);
        rd(`TSEC_OFF_LATCH, 32'h0);
    endtask
    task automatic s_wake();
        int n;
        core_idle <= 1'b1;
        wr(`TSEC_OFF_PEN_HI, 32'h0);
        wr(`TSEC_OFF_WAKE_HI, 32'h1);
        rd(`TSEC_OFF_WAKE_HI, 32'h1);
        src(32, 1'b1);
        wait_for(wake_request, n);
        check("wake delay", 32'h1, 32'(n <= 8));
        core_idle <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("wake drop", 32'h0, 32'(wake_request));
        src(32, 1'b0);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        s_reset();
        s_route();
        s_masks();
        s_global();
        s_queue();
        s_wake();
        conclude();
    end
endmodule
